// File: core/lpddr_sr_defines.svh
`ifndef LPDDR_SR_DEFINES_SVH
`define LPDDR_SR_DEFINES_SVH

// ****************************************
// Clock and timing
// ****************************************
`define CLK_MHZ 250
`define MIN_SELF_REFRESH_RESIDENCY_NS 15
`define SR_FIRST_REF_CYC ((`MIN_SELF_REFRESH_RESIDENCY_NS * `CLK_MHZ) / 1000)
`define TREFI_INT_NS 3900
`define SR_REF_INT_CYC ((`TREFI_INT_NS * `CLK_MHZ) / 1000)
`define TXSR_NS 140
`define TXSR_CYC ((`TXSR_NS * `CLK_MHZ + 999) / 1000)
`define READ_LATENCY 3

// ****************************************
// Command encodings and register indices
// ****************************************
`define CMD_SELF_REFRESH 3'h4
`define CMD_MODE_READ 4'h8
`define CMD_MODE_WRITE 4'h0
`define MA_BANK_MASK 8'h10
`define MA_SEG_MASK 8'h11
`define MASK_RESET 8'h00
`define MRR_FILL_BYTE 8'h00
`define MRR_FILL_WORD 16'h0000
`define LAST_BEAT 2'h3

`endif

// File: core/sr_mrr_pkg.sv
package sr_mrr_pkg;
  typedef enum logic [2:0] {
    SR_IDLE = 3'b001,
    SR_SELF = 3'b010,
    SR_EXIT = 3'b100
  } srState_t;

  typedef enum logic [3:0] {
    MR_IDLE = 4'b0001,
    MR_FALL = 4'b0010,
    MR_WAIT = 4'b0100,
    MR_BURST = 4'b1000
  } mrState_t;
endpackage

// File: core/self_refresh_mrr.sv
// Summary of operation
// - Entry on rising edge: CKE falls, CS_n low, CA2..0 = 100.
// - Device stays in self refresh only while CKE stays low.
// - In self refresh every input except CKE is ignored.
// - Internal all-bank refresh within minimum residency, own timer, clock off.
// - Exit recovery starts at first rising edge with CKE high.
// - Eight-bit bank mask written by register write; masked banks not refreshed.
// - Unmasked banks refresh per segment mask, same segments in every bank.
// - Segments with mask bit set are skipped in enabled banks.
// - Register read decode CA3..0 = 1000; index bits 5..0 from rising CA, bits 7..6 from falling CA.
// - Register data on DQ7..0 of first beat only.
// - Register read returns four beats after read latency, never interrupted.
// - Reserved or write-only reads give undefined data, strobes still toggle.
`timescale 1ns/1ps
`include "lpddr_sr_defines.svh"
`default_nettype none

module self_refresh_mrr
  import sr_mrr_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rstn,
  // Command link from the controller
  input wire logic ck,
  input wire logic cke,
  input wire logic csN,
  input wire logic [9:0] ca,
  // Data pins
  output logic [15:0] dqOut,
  output logic dqOe,
  output logic dqs,
  output logic dqsOe,
  // Core status
  output logic selfRefresh,
  output logic exitRecovery,
  output logic internalClkOn,
  output logic refreshStrobe,
  output logic [7:0] refreshBanks,
  output logic [7:0] refreshSegments
);

  localparam logic [9:0] FirstRefCyc = 10'(`SR_FIRST_REF_CYC);
  localparam logic [9:0] RefIntCyc = 10'(`SR_REF_INT_CYC);
  localparam logic [9:0] TxsrCyc = 10'(`TXSR_CYC);
  localparam logic [2:0] ReadLat = 3'(`READ_LATENCY);
  localparam int FirstRefMax = `SR_FIRST_REF_CYC + 1;

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic srEntryDecode(input logic ckeOld, input logic ckeNow,
                                         input logic csn, input logic [2:0] cmd);
    srEntryDecode = ckeOld && !ckeNow && !csn && (cmd == `CMD_SELF_REFRESH);
  endfunction

  function automatic logic modeDecode(input logic csn, input logic [3:0] cmd,
                                      input logic [3:0] code);
    modeDecode = !csn && (cmd == code);
  endfunction

  // ****************************************
  // Pin synchronisers and clock edges
  // ****************************************
  logic ckS1, ckS2, ckS3, ckeS1, ckeS2, csnS1, csnS2;
  logic [9:0] caS1, caS2;
  logic ckRise, ckFall;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ckS1 <= 1'b0;
      ckS2 <= 1'b0;
      ckS3 <= 1'b0;
      ckeS1 <= 1'b0;
      ckeS2 <= 1'b0;
      csnS1 <= 1'b1;
      csnS2 <= 1'b1;
      caS1 <= 10'h000;
      caS2 <= 10'h000;
    end else begin
      ckS1 <= ck;
      ckS2 <= ckS1;
      ckS3 <= ckS2;
      ckeS1 <= cke;
      ckeS2 <= ckeS1;
      csnS1 <= csN;
      csnS2 <= csnS1;
      caS1 <= ca;
      caS2 <= caS1;
    end
  end

  assign ckRise = ckS2 && !ckS3;
  assign ckFall = !ckS2 && ckS3;

  // ****************************************
  // Self refresh control
  // ****************************************
  srState_t srState_reg, srState_next;
  mrState_t mrState_reg, mrState_next;
  logic [9:0] srCnt_reg, srCnt_next;
  logic refFirst_reg, refFirst_next;
  logic ckePrev_reg, ckePrev_next;
  logic selfRefresh_reg, selfRefresh_next;
  logic exitRecovery_reg, exitRecovery_next;
  logic intClk_reg, intClk_next;
  logic refreshStrobe_reg, refreshStrobe_next;
  logic [7:0] refreshBanks_reg, refreshBanks_next;
  logic [7:0] refreshSegments_reg, refreshSegments_next;
  logic [7:0] bankMask_reg, bankMask_next;
  logic [7:0] segMask_reg, segMask_next;
  logic srEntryHit, srExitHit;

  // entry needs CKE high on the previous edge
  assign srEntryHit = ckRise && srEntryDecode(ckePrev_reg, ckeS2, csnS2, caS2[2:0])
                      && (srState_reg != SR_SELF) && (mrState_reg == MR_IDLE);
  // exit registered on the first rising edge with CKE high
  assign srExitHit = ckRise && ckeS2 && (srState_reg == SR_SELF);

  always_comb begin
    srState_next = srState_reg;
    srCnt_next = srCnt_reg;
    refFirst_next = refFirst_reg;
    ckePrev_next = ckRise ? ckeS2 : ckePrev_reg;
    selfRefresh_next = selfRefresh_reg;
    exitRecovery_next = exitRecovery_reg;
    intClk_next = intClk_reg;
    refreshStrobe_next = 1'b0;
    refreshBanks_next = refreshBanks_reg;
    refreshSegments_next = refreshSegments_reg;
    case (srState_reg)
      SR_IDLE: begin
        if (srEntryHit) begin
          srState_next = SR_SELF;
          srCnt_next = 10'h000;
          refFirst_next = 1'b1;
          selfRefresh_next = 1'b1;
          intClk_next = 1'b0;
        end
      end
      // only a registered CKE high ends the stay
      // nothing but CKE is looked at here
      SR_SELF: begin
        srCnt_next = srCnt_reg + 10'h001;
        // own timer, first all-bank refresh inside minimum residency
        if (srCnt_reg == (refFirst_reg ? FirstRefCyc : RefIntCyc)) begin
          srCnt_next = 10'h000;
          refFirst_next = 1'b0;
          refreshStrobe_next = 1'b1;
          refreshBanks_next = ~bankMask_reg;
          // segment mask applies equally to all enabled banks
          refreshSegments_next = (bankMask_reg != 8'hff) ? ~segMask_reg : `MASK_RESET;
        end
        if (srExitHit) begin
          srState_next = SR_EXIT;
          srCnt_next = 10'h000;
          selfRefresh_next = 1'b0;
          exitRecovery_next = 1'b1;
          intClk_next = 1'b1;
        end
      end
      SR_EXIT: begin
        srCnt_next = srCnt_reg + 10'h001;
        if (srEntryHit) begin
          srState_next = SR_SELF;
          srCnt_next = 10'h000;
          refFirst_next = 1'b1;
          selfRefresh_next = 1'b1;
          exitRecovery_next = 1'b0;
          intClk_next = 1'b0;
        end else if (srCnt_reg == TxsrCyc - 10'h001) begin
          srState_next = SR_IDLE;
          exitRecovery_next = 1'b0;
        end
      end
      default: begin
        srState_next = SR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      srState_reg <= SR_IDLE;
      srCnt_reg <= 10'h000;
      refFirst_reg <= 1'b1;
      ckePrev_reg <= 1'b0;
      selfRefresh_reg <= 1'b0;
      exitRecovery_reg <= 1'b0;
      intClk_reg <= 1'b1;
      refreshStrobe_reg <= 1'b0;
      refreshBanks_reg <= `MASK_RESET;
      refreshSegments_reg <= `MASK_RESET;
    end else begin
      srState_reg <= srState_next;
      srCnt_reg <= srCnt_next;
      refFirst_reg <= refFirst_next;
      ckePrev_reg <= ckePrev_next;
      selfRefresh_reg <= selfRefresh_next;
      exitRecovery_reg <= exitRecovery_next;
      intClk_reg <= intClk_next;
      refreshStrobe_reg <= refreshStrobe_next;
      refreshBanks_reg <= refreshBanks_next;
      refreshSegments_reg <= refreshSegments_next;
    end
  end

  // ****************************************
  // Mode register read and write
  // ****************************************
  logic isWrite_reg, isWrite_next;
  logic [5:0] caHi_reg, caHi_next;
  logic [7:0] mrrIndex_reg, mrrIndex_next;
  logic [7:0] mrrWord_reg, mrrWord_next;
  logic [2:0] latCnt_reg, latCnt_next;
  logic [1:0] beatIdx_reg, beatIdx_next;
  logic [15:0] dqOut_reg, dqOut_next;
  logic dqOe_reg, dqOe_next, dqs_reg, dqs_next, dqsOe_reg, dqsOe_next;
  logic cmdOk;
  logic [7:0] fallIndex;

  assign cmdOk = ckRise && (srState_reg == SR_IDLE) && ckePrev_reg && ckeS2;
  assign fallIndex = {caS2[1:0], caHi_reg};

  always_comb begin
    mrState_next = mrState_reg;
    isWrite_next = isWrite_reg;
    caHi_next = caHi_reg;
    mrrIndex_next = mrrIndex_reg;
    mrrWord_next = mrrWord_reg;
    latCnt_next = latCnt_reg;
    beatIdx_next = beatIdx_reg;
    dqOut_next = dqOut_reg;
    dqOe_next = dqOe_reg;
    dqs_next = dqs_reg;
    dqsOe_next = dqsOe_reg;
    bankMask_next = bankMask_reg;
    segMask_next = segMask_reg;
    case (mrState_reg)
      MR_IDLE: begin
        // read decoded at the rising edge, lower six index bits kept
        if (cmdOk && modeDecode(csnS2, caS2[3:0], `CMD_MODE_READ)) begin
          mrState_next = MR_FALL;
          isWrite_next = 1'b0;
          caHi_next = caS2[9:4];
        end else if (cmdOk && modeDecode(csnS2, caS2[3:0], `CMD_MODE_WRITE)) begin
          mrState_next = MR_FALL;
          isWrite_next = 1'b1;
          caHi_next = caS2[9:4];
        end
      end
      MR_FALL: begin
        if (ckFall) begin
          if (isWrite_reg) begin
            mrState_next = MR_IDLE;
            // bank mask loaded by register write
            if (fallIndex == `MA_BANK_MASK) begin
              bankMask_next = caS2[9:2];
            end
            if (fallIndex == `MA_SEG_MASK) begin
              segMask_next = caS2[9:2];
            end
          end else begin
            mrState_next = MR_WAIT;
            mrrIndex_next = fallIndex;
            // no readable register here, every index returns fill
            mrrWord_next = `MRR_FILL_BYTE;
            latCnt_next = 3'h0;
          end
        end
      end
      // burst starts after read latency and new commands are not decoded
      MR_WAIT: begin
        if (ckRise) begin
          latCnt_next = latCnt_reg + 3'h1;
          if (latCnt_reg == ReadLat - 3'h1) begin
            mrState_next = MR_BURST;
            beatIdx_next = 2'h0;
            dqOe_next = 1'b1;
            dqsOe_next = 1'b1;
            dqs_next = 1'b1;
            // register byte on DQ7..0 of the first beat only
            dqOut_next = {`MRR_FILL_BYTE, mrrWord_reg};
          end
        end
      end
      MR_BURST: begin
        if (ckRise || ckFall) begin
          if (beatIdx_reg == `LAST_BEAT) begin
            mrState_next = MR_IDLE;
            dqOe_next = 1'b0;
            dqsOe_next = 1'b0;
            dqs_next = 1'b0;
            dqOut_next = `MRR_FILL_WORD;
          end else begin
            beatIdx_next = beatIdx_reg + 2'h1;
            // strobe keeps toggling on every beat
            dqs_next = !dqs_reg;
            dqOut_next = `MRR_FILL_WORD;
          end
        end
      end
      default: begin
        mrState_next = MR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mrState_reg <= MR_IDLE;
      isWrite_reg <= 1'b0;
      caHi_reg <= 6'h00;
      mrrIndex_reg <= 8'h00;
      mrrWord_reg <= `MRR_FILL_BYTE;
      latCnt_reg <= 3'h0;
      beatIdx_reg <= 2'h0;
      dqOut_reg <= `MRR_FILL_WORD;
      dqOe_reg <= 1'b0;
      dqs_reg <= 1'b0;
      dqsOe_reg <= 1'b0;
      bankMask_reg <= `MASK_RESET;
      segMask_reg <= `MASK_RESET;
    end else begin
      mrState_reg <= mrState_next;
      isWrite_reg <= isWrite_next;
      caHi_reg <= caHi_next;
      mrrIndex_reg <= mrrIndex_next;
      mrrWord_reg <= mrrWord_next;
      latCnt_reg <= latCnt_next;
      beatIdx_reg <= beatIdx_next;
      dqOut_reg <= dqOut_next;
      dqOe_reg <= dqOe_next;
      dqs_reg <= dqs_next;
      dqsOe_reg <= dqsOe_next;
      bankMask_reg <= bankMask_next;
      segMask_reg <= segMask_next;
    end
  end

  assign dqOut = dqOut_reg;
  assign dqOe = dqOe_reg;
  assign dqs = dqs_reg;
  assign dqsOe = dqsOe_reg;
  assign selfRefresh = selfRefresh_reg;
  assign exitRecovery = exitRecovery_reg;
  assign internalClkOn = intClk_reg;
  assign refreshStrobe = refreshStrobe_reg;
  assign refreshBanks = refreshBanks_reg;
  assign refreshSegments = refreshSegments_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence srEnter;
    srEntryHit ##1 (selfRefresh_reg && !intClk_reg);
  endsequence

  chk_sr_entry: assert property (srEntryHit |-> srEnter)
    else $error("self refresh entry not taken");
  chk_sr_hold: assert property ((srState_reg == SR_SELF && !srExitHit) |=>
    (srState_reg == SR_SELF)) else $error("self refresh left without CKE high");
  chk_sr_ignore: assert property ((srState_reg == SR_SELF) |=>
    (mrState_reg == MR_IDLE && $stable(bankMask_reg) && $stable(segMask_reg)))
    else $error("command taken during self refresh");
  chk_first_refresh: assert property ($rose(selfRefresh_reg) |->
    ##[0:FirstRefMax] (refreshStrobe_reg || !selfRefresh_reg))
    else $error("no internal refresh inside minimum residency");
  chk_exit_recovery: assert property (srExitHit |=>
    (exitRecovery_reg && !selfRefresh_reg) [*8])
    else $error("exit recovery not started at exit edge");
  chk_bank_mask: assert property (refreshStrobe_reg |->
    ((refreshBanks_reg & bankMask_reg) == 8'h00))
    else $error("masked bank refreshed");
  chk_seg_banks: assert property ((refreshStrobe_reg && refreshBanks_reg != 8'h00) |->
    (refreshSegments_reg == ~segMask_reg)) else $error("segment mask not common");
  chk_seg_mask: assert property (refreshStrobe_reg |->
    ((refreshSegments_reg & segMask_reg) == 8'h00))
    else $error("masked segment refreshed");
  chk_mrr_index: assert property ((mrState_reg == MR_FALL && ckFall && !isWrite_reg)
    |=> (mrrIndex_reg == {$past(caS2[1:0]), caHi_reg}))
    else $error("register index misassembled");
  chk_first_beat: assert property ($rose(dqOe_reg) |->
    (dqOut_reg[7:0] == mrrWord_reg && beatIdx_reg == 2'h0))
    else $error("register byte missing on first beat");
  chk_burst_four: assert property ($fell(dqOe_reg) |->
    ($past(beatIdx_reg) == `LAST_BEAT)) else $error("burst not four beats");
  chk_strobe_toggle: assert property ((dqOe_reg && (ckRise || ckFall) &&
    beatIdx_reg != `LAST_BEAT) |=> (dqs_reg != $past(dqs_reg) && dqsOe_reg))
    else $error("strobe did not toggle");

endmodule

`default_nettype wire

// File: testbench/lpddr_ctrl_model.sv
`timescale 1ns/1ps
`include "lpddr_sr_defines.svh"
`default_nettype none

// ****************************************
// Memory controller model
// ****************************************
module lpddr_ctrl_model #(
  // All-bank refresh code, not decoded by this device
  parameter logic [3:0] REF_ALL_CODE = 4'hc
) (
  // Link pins
  output logic ck,
  output logic cke,
  output logic csN,
  output logic [9:0] ca
);
  initial begin
    ck = 1'b0;
    cke = 1'b0;
    csN = 1'b1;
    ca = 10'h000;
  end

  // One link cycle; pins settle a quarter period before each edge
  task automatic slot(input logic c, input logic cs, input logic [9:0] r, input logic [9:0] f);
    cke = c;
    csN = cs;
    ca = r;
    #31.25 ck = 1'b1;
    #31.25 ca = f;
    #31.25 ck = 1'b0;
    #31.25;
  endtask

  // Deselected: CA lines carry the inverse of their last value at the rising edge, then that value again
  task automatic nop(input logic c);
    slot(c, 1'b1, ~ca, ca);
  endtask

  task automatic mrr(input logic [7:0] idx);
    slot(1'b1, 1'b0, {idx[5:0], `CMD_MODE_READ}, {8'h00, idx[7:6]});
    // only NOPs until the burst is over
    repeat (6) nop(1'b1);
  endtask

  task automatic mode_register_write(input logic [7:0] idx, input logic [7:0] d);
    slot(1'b1, 1'b0, {idx[5:0], `CMD_MODE_WRITE}, {d, idx[7:6]});
    repeat (5) nop(1'b1);
  endtask

  // banks idle, entry, NOP with CKE low, clock then stops
  task automatic enter();
    slot(1'b0, 1'b0, {7'h00, `CMD_SELF_REFRESH}, ~ca);
    nop(1'b0);
  endtask

  // clock back for two cycles, CKE still low
  task automatic leave();
    repeat (2) slot(1'b0, 1'b0, {6'h00, `CMD_MODE_READ}, 10'h000);
    // CKE high and NOPs through recovery
    repeat (3) nop(1'b1);
  endtask

  // one all-bank refresh before any new entry
  task automatic refresh();
    slot(1'b1, 1'b0, {6'h00, REF_ALL_CODE}, ca);
    nop(1'b1);
  endtask
endmodule

`default_nettype wire

// File: testbench/test_self_refresh_partial_array_self_refresh_mode_read.sv
`timescale 1ns/1ps
`include "lpddr_sr_defines.svh"
`default_nettype none

`define CHECK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module test_self_refresh_partial_array_self_refresh_mode_read
  import sr_mrr_pkg::*;
;
  typedef struct {logic [7:0] idx; logic [15:0] word;} mrrRow_t;
  logic clk;
  logic rstn;
  wire logic ck;
  wire logic cke;
  wire logic csN;
  wire logic [9:0] ca;
  logic [15:0] dqOut;
  logic dqOe, dqs, dqsOe, selfRefresh, exitRecovery, internalClkOn, refreshStrobe;
  logic [7:0] refreshBanks;
  logic [7:0] refreshSegments;
  int oeSeen = 0;
  int oeBase;
  int mismatches = 0;
  int compares = 0;
  int n;
  int strobes;
  mrrRow_t rows[4] = '{'{8'h10, `MRR_FILL_WORD}, '{8'h11, `MRR_FILL_WORD},
                       '{8'h05, `MRR_FILL_WORD}, '{8'hff, `MRR_FILL_WORD}};

  self_refresh_mrr i_dut (.clk(clk), .rstn(rstn), .ck(ck), .cke(cke), .csN(csN), .ca(ca),
    .dqOut(dqOut), .dqOe(dqOe), .dqs(dqs), .dqsOe(dqsOe), .selfRefresh(selfRefresh),
    .exitRecovery(exitRecovery), .internalClkOn(internalClkOn),
    .refreshStrobe(refreshStrobe), .refreshBanks(refreshBanks),
    .refreshSegments(refreshSegments));
  lpddr_ctrl_model i_ctrl (.ck(ck), .cke(cke), .csN(csN), .ca(ca));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (dqOe === 1'b1) begin
      oeSeen <= oeSeen + 1;
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic close_out();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic waitOn(input int sel, input logic val, input int bound, output int cnt);
    logic s;
    cnt = 0;
    s = ~val;
    while (s !== val) begin
      if (cnt == bound) begin
        mismatches++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, s, val);
        close_out();
      end
      @(posedge clk);
      #1;
      cnt++;
      case (sel)
        0: s = dqOe;
        1: s = dqs;
        2: s = selfRefresh;
        3: s = exitRecovery;
        default: s = refreshStrobe;
      endcase
    end
  endtask

  task automatic readCheck(input mrrRow_t row);
    int k;
    fork
      i_ctrl.mrr(row.idx);
      begin
        waitOn(0, 1'b1, 200, k);
        `CHECK(k >= (`READ_LATENCY * 125 + 31) / 4 && k <= 109, 1'b1)
        for (int b = 0; b < 4; b++) begin
          if (b > 0) begin
            waitOn(1, ~b[0], 40, k);
          end
          `CHECK(dqOut, (b == 0) ? row.word : `MRR_FILL_WORD)
          `CHECK({dqOe, dqsOe}, 2'b11)
        end
        waitOn(0, 1'b0, 40, k);
        `CHECK(k <= 20, 1'b1)
      end
    join
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    `CHECK({dqOe, dqsOe, selfRefresh, exitRecovery, internalClkOn, refreshStrobe}, 6'h02)
    repeat (2) i_ctrl.nop(1'b1);
    foreach (rows[i]) begin
      readCheck(rows[i]);
    end
    i_ctrl.mode_register_write(`MA_BANK_MASK, 8'h82);
    i_ctrl.mode_register_write(`MA_SEG_MASK, 8'h84);
    i_ctrl.mode_register_write(8'h12, 8'hff);
    fork
      i_ctrl.enter();
      begin
        waitOn(2, 1'b1, 200, n);
        `CHECK(internalClkOn, 1'b0)
        waitOn(4, 1'b1, `SR_FIRST_REF_CYC + 3, n);
        `CHECK(refreshBanks, 8'h7d)
        `CHECK(refreshSegments, 8'h7b)
      end
    join
    strobes = 0;
    repeat (`SR_REF_INT_CYC + 4) begin
      @(posedge clk);
      #1;
      if (refreshStrobe === 1'b1) begin
        strobes++;
      end
    end
    `CHECK(strobes, 1)
    `CHECK(refreshSegments, 8'h7b)
    `CHECK(selfRefresh, 1'b1)
    oeBase = oeSeen;
    fork
      i_ctrl.leave();
      begin
        waitOn(3, 1'b1, 400, n);
        `CHECK({selfRefresh, internalClkOn}, 2'b01)
        waitOn(3, 1'b0, 100, n);
        `CHECK(n, `TXSR_CYC)
      end
    join
    i_ctrl.nop(1'b1);
    `CHECK(oeSeen, oeBase)
    i_ctrl.refresh();
    readCheck(rows[0]);
    // ****************************************
    // All banks masked, then reset inside self refresh
    // ****************************************
    i_ctrl.mode_register_write(`MA_BANK_MASK, 8'hff);
    fork
      i_ctrl.enter();
      begin
        waitOn(4, 1'b1, 200, n);
        `CHECK({refreshBanks, refreshSegments}, 16'h0000)
      end
    join
    `CHECK(selfRefresh, 1'b1)
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    `CHECK({dqOe, dqsOe, selfRefresh, exitRecovery, internalClkOn, refreshStrobe}, 6'h02)
    close_out();
  end
endmodule

`default_nettype wire
